// *** design/ida_pkg.sv ***
// shared constants and carriers for the indirect data array window
package ida_pkg;
  // 32-bit parameters travel as two 16-bit halves, low half first
  localparam int unsigned IDA_WORD_W = 32;
  localparam int unsigned IDA_HALF_W = 16;
  localparam int unsigned IDA_DEPTH_DEF = 256;
  // parameter select codes
  localparam logic [1:0] IDA_SEL_CAPACITY = 2'h0;
  localparam logic [1:0] IDA_SEL_INDEX = 2'h1;
  localparam logic [1:0] IDA_SEL_FIXED = 2'h2;
  localparam logic [1:0] IDA_SEL_STEPPING = 2'h3;
  // reset values and index step
  localparam logic [31:0] IDA_INDEX_RST = 32'h0000_0000;
  localparam logic [15:0] IDA_HALF_RST = 16'h0000;
  localparam logic [31:0] IDA_STEP = 32'h0000_0001;

  typedef struct packed {
    logic valid;
    logic write;
    logic keypad;
    logic [1:0] sel;
    logic high;
    logic [IDA_HALF_W-1:0] wdata;
  } ida_req_type;

  typedef struct packed {
    logic valid;
    logic refused;
    logic [IDA_HALF_W-1:0] rdata;
  } ida_rsp_type;
endpackage : ida_pkg

// *** design/ida_window.sv ***
// index register and two data windows in front of the word array
// Operation
// - keypad write to fixed window stores at index, then index plus one
// - stepping window refuses keypad writes
// - stepping window read returns word at index, then index plus one
// - keypad read of fixed window returns word, index unchanged
// - six-word link write sets index, stores fixed then stepping value
// - single link write to index loads the new index
// - six-word link read returns index, word, next word; index ends +2
// - link read or write of either window steps index by one
// - array holds 32-bit words; capacity readable, read only
`timescale 1ns/1ps
`default_nettype none
module ida_window #(
  parameter int unsigned DEPTH = ida_pkg::IDA_DEPTH_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire ida_pkg::ida_req_type req,
  output ida_pkg::ida_rsp_type rsp
);
  import ida_pkg::*;

  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [31:0] CAPACITY = 32'(DEPTH);

  // the array must have at least two words and an address that fits
  if (DEPTH < 2 || DEPTH > 32'h0010_0000)
  begin : g_bad_depth
    $error("ida_window: DEPTH out of range");
  end

  logic [31:0] index_q;
  logic [31:0] index_d;
  logic [15:0] wlo_q;
  logic [15:0] wlo_d;
  logic [15:0] rhi_q;
  logic [15:0] rhi_d;
  ida_rsp_type rsp_q;
  ida_rsp_type rsp_d;
  logic wr_en;
  logic [31:0] wr_full;
  logic [31:0] rd_data;
  logic [31:0] word_at;
  logic in_range;
  logic refuse;

  ida_word_array #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_array (
    .clk(clk),
    .wr_en(wr_en),
    .wr_addr(index_q[AW-1:0]),
    .wr_data(wr_full),
    .rd_addr(index_q[AW-1:0]),
    .rd_data(rd_data)
  );

  // an index past the end reads zero and drops writes but still steps
  assign in_range = (index_q < CAPACITY);
  assign word_at = in_range ? rd_data : 32'h0000_0000;
  assign wr_full = {req.wdata, wlo_q};
  assign refuse = (req.sel == IDA_SEL_CAPACITY) ||
                  (req.sel == IDA_SEL_STEPPING && req.keypad);

  // word-level access: a write acts on its high half, a read on its low
  // half, so a six-word link burst touches index and both windows in order
  always_comb
  begin
    index_d = index_q;
    wlo_d = wlo_q;
    rhi_d = rhi_q;
    rsp_d = '0;
    wr_en = 1'b0;
    if (req.valid)
    begin
      rsp_d.valid = 1'b1;
      if (req.write)
      begin
        if (refuse)
        begin
          rsp_d.refused = 1'b1;
        end
        else if (!req.high)
        begin
          wlo_d = req.wdata;
        end
        else
        begin
          case (req.sel)
            IDA_SEL_INDEX:
            begin
              index_d = wr_full;
            end
            default:
            begin
              wr_en = in_range;
              index_d = index_q + IDA_STEP;
            end
          endcase
        end
      end
      else if (req.high)
      begin
        rsp_d.rdata = rhi_q; // high half captured with the low half
      end
      else
      begin
        case (req.sel)
          IDA_SEL_CAPACITY:
          begin
            rsp_d.rdata = CAPACITY[15:0];
            rhi_d = CAPACITY[31:16];
          end
          IDA_SEL_INDEX:
          begin
            rsp_d.rdata = index_q[15:0];
            rhi_d = index_q[31:16];
          end
          IDA_SEL_FIXED:
          begin
            rsp_d.rdata = word_at[15:0];
            rhi_d = word_at[31:16];
            if (!req.keypad)
            begin
              index_d = index_q + IDA_STEP;
            end
          end
          default:
          begin
            rsp_d.rdata = word_at[15:0];
            rhi_d = word_at[31:16];
            index_d = index_q + IDA_STEP;
          end
        endcase
      end
    end
  end

  // state registers only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      index_q <= IDA_INDEX_RST;
      wlo_q <= IDA_HALF_RST;
      rhi_q <= IDA_HALF_RST;
      rsp_q <= '0;
    end
    else
    begin
      index_q <= index_d;
      wlo_q <= wlo_d;
      rhi_q <= rhi_d;
      rsp_q <= rsp_d;
    end
  end

  assign rsp = rsp_q;

  // helper decodes for the checks below
  logic w_hi;
  logic r_lo;
  assign w_hi = req.valid && req.write && req.high;
  assign r_lo = req.valid && !req.write && !req.high;

  property p_keypad_fixed_write;
    @(posedge clk) disable iff (!rst_n)
    w_hi && req.keypad && req.sel == IDA_SEL_FIXED
      |=> index_q == $past(index_q) + IDA_STEP;
  endproperty
  a_keypad_fixed_write: assert property (p_keypad_fixed_write)
    else $error("keypad fixed write did not step index");

  property p_keypad_step_refused;
    @(posedge clk) disable iff (!rst_n)
    req.valid && req.write && req.keypad && req.sel == IDA_SEL_STEPPING
      |-> !wr_en ##1 (rsp.refused && index_q == $past(index_q));
  endproperty
  a_keypad_step_refused: assert property (p_keypad_step_refused)
    else $error("keypad write to stepping window not refused");

  property p_step_read;
    @(posedge clk) disable iff (!rst_n)
    r_lo && req.sel == IDA_SEL_STEPPING
      |=> index_q == $past(index_q) + IDA_STEP &&
          rsp.rdata == $past(word_at[15:0]);
  endproperty
  a_step_read: assert property (p_step_read)
    else $error("stepping read wrong data or index");

  property p_keypad_fixed_read;
    @(posedge clk) disable iff (!rst_n)
    r_lo && req.keypad && req.sel == IDA_SEL_FIXED
      |=> $stable(index_q) && rsp.rdata == $past(word_at[15:0]);
  endproperty
  a_keypad_fixed_read: assert property (p_keypad_fixed_read)
    else $error("keypad fixed read moved index");

  // look in the array itself, so a lost or misplaced store is caught
  property p_window_write_stores;
    @(posedge clk) disable iff (!rst_n)
    w_hi && !refuse && req.sel != IDA_SEL_INDEX && in_range
      |=> u_array.mem[$past(index_q[AW-1:0])] ==
          {$past(req.wdata), $past(wlo_q)};
  endproperty
  a_window_write_stores: assert property (p_window_write_stores)
    else $error("window write did not store low then high");

  property p_index_load;
    @(posedge clk) disable iff (!rst_n)
    w_hi && req.sel == IDA_SEL_INDEX
      |=> index_q == {$past(req.wdata), $past(wlo_q)};
  endproperty
  a_index_load: assert property (p_index_load)
    else $error("index write not loaded");

  property p_index_read;
    @(posedge clk) disable iff (!rst_n)
    r_lo && req.sel == IDA_SEL_INDEX
      |=> rsp.valid && rsp.rdata == $past(index_q[15:0]) &&
          rhi_q == $past(index_q[31:16]);
  endproperty
  a_index_read: assert property (p_index_read)
    else $error("index read returned wrong value");

  property p_link_window_step;
    @(posedge clk) disable iff (!rst_n)
    req.valid && !req.keypad && !refuse && req.sel[1] &&
      (req.write ? req.high : !req.high)
      |=> index_q == $past(index_q) + IDA_STEP;
  endproperty
  a_link_window_step: assert property (p_link_window_step)
    else $error("link window access did not step index");

  property p_capacity;
    @(posedge clk) disable iff (!rst_n)
    r_lo && req.sel == IDA_SEL_CAPACITY
      |=> rsp.rdata == CAPACITY[15:0] && rhi_q == CAPACITY[31:16];
  endproperty
  a_capacity: assert property (p_capacity)
    else $error("capacity read wrong");
endmodule : ida_window
`default_nettype wire

// *** design/ida_word_array.sv ***
// storage for the 32-bit data words: one write port, one read port
`timescale 1ns/1ps
`default_nettype none
module ida_word_array #(
  parameter int unsigned DEPTH = ida_pkg::IDA_DEPTH_DEF,
  parameter int unsigned AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [ida_pkg::IDA_WORD_W-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [ida_pkg::IDA_WORD_W-1:0] rd_data
);
  import ida_pkg::*;

  logic [IDA_WORD_W-1:0] mem [DEPTH];

  // contents are not reset; software loads them before use
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read is combinational so the top can register the answer in one cycle
  assign rd_data = mem[rd_addr];
endmodule : ida_word_array
`default_nettype wire

// *** verification/ida_master.sv ***
// link master and keypad model: one half-word access at a time
`timescale 1ns/1ps
`default_nettype none
module ida_master (
  input wire logic clk,
  input wire ida_pkg::ida_rsp_type rsp,
  output ida_pkg::ida_req_type req
);
  import ida_pkg::*;
  initial req = '0;
  // request stands for one edge, the answer is taken one edge later
  task automatic acc(input logic w, input logic kp, input logic [1:0] sel,
    input logic hi, input logic [15:0] wd, output logic [15:0] rd,
    output logic [1:0] st);
    @(posedge clk);
    req <= '{1'b1, w, kp, sel, hi, wd};
    @(posedge clk);
    req.valid <= 1'b0;
    req.wdata <= ~wd; // released data must not keep its last value
    #1;
    rd = rsp.rdata;
    st = {rsp.valid, rsp.refused};
  endtask : acc
endmodule : ida_master
`default_nettype wire

// *** verification/ida_window_test.sv ***
// self-checking bench for the indirect data array window
`timescale 1ns/1ps
`default_nettype none
module ida_window_test;
  import ida_pkg::*;
  typedef struct packed {
    logic kp;
    logic w;
    logic [1:0] sel;
    logic [31:0] d;
  } ida_row_type;
  logic clk;
  logic rst_n;
  ida_req_type req;
  ida_rsp_type rsp;
  int fail_count;
  int num_checks;
  int cycles;
  // kept small: indices 11 to 17 fit in its 32 words, while 43 to 45 lie past the end
  ida_window #(.DEPTH(32)) DUT (.clk(clk), .rst_n(rst_n), .req(req),
    .rsp(rsp));
  ida_master M (.clk(clk), .rsp(rsp), .req(req));
  // keypad walk over locations 11..13, then link access
  ida_row_type rows [11] = '{
    '{1'b0, 1'b1, IDA_SEL_INDEX, 32'h0000_000b},
    '{1'b1, 1'b1, IDA_SEL_FIXED, 32'h0001_0064},
    '{1'b1, 1'b1, IDA_SEL_FIXED, 32'h0002_00c8},
    '{1'b1, 1'b1, IDA_SEL_FIXED, 32'h0003_012c},
    '{1'b1, 1'b0, IDA_SEL_INDEX, 32'h0000_000e},
    '{1'b0, 1'b1, IDA_SEL_INDEX, 32'h0000_000b},
    '{1'b1, 1'b0, IDA_SEL_FIXED, 32'h0001_0064},
    '{1'b1, 1'b0, IDA_SEL_STEPPING, 32'h0001_0064},
    '{1'b1, 1'b0, IDA_SEL_STEPPING, 32'h0002_00c8},
    '{1'b0, 1'b0, IDA_SEL_FIXED, 32'h0003_012c},
    '{1'b0, 1'b0, IDA_SEL_INDEX, 32'h0000_000e}};
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // full word write, low half first; status checked on both halves
  task automatic wr32(input logic kp, input logic [1:0] sel,
    input logic [31:0] d, input logic [1:0] st_exp);
    logic [15:0] rd;
    logic [1:0] st;
    M.acc(1'b1, kp, sel, 1'b0, d[15:0], rd, st);
    chk({30'h0, st}, {30'h0, st_exp});
    M.acc(1'b1, kp, sel, 1'b1, d[31:16], rd, st);
    chk({30'h0, st}, {30'h0, st_exp});
  endtask : wr32
  task automatic rdc(input logic kp, input logic [1:0] sel,
    input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0] st;
    M.acc(1'b0, kp, sel, 1'b0, 16'h0000, v[15:0], st);
    chk({30'h0, st}, {30'h0, 2'b10});
    M.acc(1'b0, kp, sel, 1'b1, 16'h0000, v[31:16], st);
    chk({30'h0, st}, {30'h0, 2'b10});
    chk(v, exp);
  endtask : rdc
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // a hang is cut short well beyond the roughly 125 cycles needed
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fail_count++;
      end_sim();
    end
  end
  initial
  begin
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i])
      if (rows[i].w)
        wr32(rows[i].kp, rows[i].sel, rows[i].d, 2'b10);
      else
        rdc(rows[i].kp, rows[i].sel, rows[i].d);
    // six-word link burst write then burst read back
    wr32(1'b0, IDA_SEL_INDEX, 32'h0000_000f, 2'b10);
    wr32(1'b0, IDA_SEL_FIXED, 32'h0005_01f4, 2'b10);
    wr32(1'b0, IDA_SEL_STEPPING, 32'h0006_0258, 2'b10);
    wr32(1'b0, IDA_SEL_INDEX, 32'h0000_000f, 2'b10);
    rdc(1'b0, IDA_SEL_INDEX, 32'h0000_000f);
    rdc(1'b0, IDA_SEL_FIXED, 32'h0005_01f4);
    rdc(1'b0, IDA_SEL_STEPPING, 32'h0006_0258);
    rdc(1'b0, IDA_SEL_INDEX, 32'h0000_0011);
    // refused writes must leave index and capacity alone
    wr32(1'b1, IDA_SEL_STEPPING, 32'h0000_dead, 2'b11);
    wr32(1'b0, IDA_SEL_CAPACITY, 32'h0000_0001, 2'b11);
    rdc(1'b0, IDA_SEL_INDEX, 32'h0000_0011);
    rdc(1'b1, IDA_SEL_CAPACITY, 32'h0000_0020);
    // past the end: reads give zero, writes are dropped, index still steps
    wr32(1'b0, IDA_SEL_INDEX, 32'h0000_002b, 2'b10);
    rdc(1'b0, IDA_SEL_FIXED, 32'h0000_0000);
    wr32(1'b1, IDA_SEL_FIXED, 32'hffff_ffff, 2'b10);
    rdc(1'b0, IDA_SEL_INDEX, 32'h0000_002d);
    // location 44 would alias onto 12 if the dropped write had landed
    wr32(1'b0, IDA_SEL_INDEX, 32'h0000_000c, 2'b10);
    rdc(1'b1, IDA_SEL_FIXED, 32'h0002_00c8);
    // second reset in mid-run clears the index
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdc(1'b0, IDA_SEL_INDEX, 32'h0000_0000);
    end_sim();
  end
endmodule : ida_window_test
`default_nettype wire
